// ---- include/prb_pkg.sv ----
// Constants for the bank-organised output register block.
// Assumes one register clock and a plain register port with 32-bit data.
package prb_pkg;

  // Geometry: four banks of four flip-flops each.
  localparam int NUM_BANKS = 4;
  localparam int BANK_W    = 4;
  localparam int NUM_FF    = 16;
  localparam int TERM_W    = 4;
  localparam int ADDR_W    = 6;
  localparam int DATA_W    = 32;
  localparam int SET_W     = 2;

  // Bank indices; the last two exist only in the variant with M-pin banks.
  localparam int BANK_LOWER  = 0;
  localparam int BANK_UPPER  = 1;
  localparam int BANK_M_LOW  = 2;
  localparam int BANK_M_HIGH = 3;

  // Per-bank load setting codes.
  localparam logic [SET_W-1:0] LOAD_NONE = 2'h0;
  localparam logic [SET_W-1:0] LOAD_ZERO = 2'h1;
  localparam logic [SET_W-1:0] LOAD_ONE  = 2'h2;
  localparam logic [SET_W-1:0] LOAD_TERM = 2'h3;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_LOAD_SET  = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_TERM_MASK = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_FF_TYPE   = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_OE_TERM   = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_INPUT_FN  = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_VARIANT   = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_FF_STATE  = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_PIN_STATE = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 6'h20;

  // Register field widths.
  localparam int LOAD_SET_W  = NUM_BANKS * SET_W;
  localparam int TERM_MASK_W = NUM_BANKS * TERM_W;

  // Reset values.
  localparam logic [LOAD_SET_W-1:0]  RST_LOAD_SET  = 8'h00;
  localparam logic [TERM_MASK_W-1:0] RST_TERM_MASK = 16'h0000;
  localparam logic [NUM_BANKS-1:0]   RST_FF_TYPE   = 4'h0;
  localparam logic [NUM_FF-1:0]      RST_OE_TERM   = 16'h0000;
  localparam logic [NUM_BANKS-1:0]   RST_INPUT_FN  = 4'h0;
  localparam logic                   RST_VARIANT   = 1'b0;
  localparam logic [DATA_W-1:0]      RD_IDLE       = 32'h00000000;

endpackage

// ---- core/prb_ff_cell.sv ----
// One J-K flip-flop of a register bank, fed from the array and from its pin.
// Assumes the caller decides per bank whether the pin is loading this edge.
`timescale 1ns/1ps

module prb_ff_cell (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Array side
  input  wire logic arrayJ,
  input  wire logic arrayK,
  // Pin side
  input  wire logic pinBit,
  input  wire logic loadNow,
  // Mode
  input  wire logic dType,
  input  wire logic maskArray,
  // State
  output logic      q
);

  logic arrJ;
  logic arrK;
  logic pinJ;
  logic pinK;
  logic jIn;
  logic kIn;

  // Masking hides the array terms while the bank loads from pins.
  assign arrJ = arrayJ & ~(maskArray & loadNow);
  assign arrK = arrayK & ~(maskArray & loadNow);
  assign pinJ = loadNow & pinBit;
  assign pinK = loadNow & ~pinBit;
  // A high from either source wins over a low from the other.
  assign jIn  = arrJ | pinJ;
  // In D mode K is the inverse of J, so the toggle case cannot arise.
  assign kIn  = dType ? ~jIn : (arrK | pinK);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= 1'b0;
    end else begin
      case ({jIn, kIn})
        2'b10:   q <= 1'b1;
        2'b01:   q <= 1'b0;
        2'b11:   q <= ~q;
        default: q <= q;
      endcase
    end
  end

endmodule // prb_ff_cell

// ---- core/prb_register_bank.sv ----
// Bank-organised output flip-flops with direct load from their pins.
// Assumes pins and product-term inputs are asynchronous to sys_clk, the
// array terms come from logic on sys_clk, and software programs the
// configuration over the plain register port.
//
// Behaviour
// - Lower and upper banks each have load control.
// - M-pin variant adds two more bank controls.
// - Control at one: bank captures pins each clock.
// - Control at zero: array-loaded, outputs drive pins.
// - Single product term selects pin or array.
// - Unconfigured control leaves pin loading disabled.
// - Input function applies to whole bank only.
// - Input banks drop output enables, never contend.
// - High J or K from either source dominates.
// - J and K both high toggles the flop.
// - D mode makes K the inverse of J.
// - Masking variant blocks array terms during load.
`timescale 1ns/1ps

module prb_register_bank (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        arst_n,
  // Register port
  input  wire logic [prb_pkg::ADDR_W-1:0]  regAddr,
  input  wire logic [prb_pkg::DATA_W-1:0]  regWdata,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [prb_pkg::DATA_W-1:0]  regRdata,
  // Logic array side
  input  wire logic [prb_pkg::NUM_FF-1:0]  arrayJ,
  input  wire logic [prb_pkg::NUM_FF-1:0]  arrayK,
  output logic      [prb_pkg::NUM_FF-1:0]  flopQ,
  // Product-term inputs
  input  wire logic [prb_pkg::TERM_W-1:0]  termIn,
  // Pins
  input  wire logic [prb_pkg::NUM_FF-1:0]  pinIn,
  output logic      [prb_pkg::NUM_FF-1:0]  pinOut,
  output logic      [prb_pkg::NUM_FF-1:0]  pinOe
);

  // Configuration registers.
  logic [prb_pkg::LOAD_SET_W-1:0]  bankLoadSetting_r;
  logic [prb_pkg::TERM_MASK_W-1:0] termMask_r;
  logic [prb_pkg::NUM_BANKS-1:0]   dType_r;
  logic [prb_pkg::NUM_FF-1:0]      pinOutputEnableTerm_r;
  logic [prb_pkg::NUM_BANKS-1:0]   registeredPinInputFn_r;
  logic                            variantM_r;

  // Input synchronisers: three stages, then a filtered value.
  logic [prb_pkg::NUM_FF-1:0]      pinS1_r;
  logic [prb_pkg::NUM_FF-1:0]      pinS2_r;
  logic [prb_pkg::NUM_FF-1:0]      pinS3_r;
  logic [prb_pkg::NUM_FF-1:0]      pinSync_r;
  logic [prb_pkg::TERM_W-1:0]      termS1_r;
  logic [prb_pkg::TERM_W-1:0]      termS2_r;
  logic [prb_pkg::TERM_W-1:0]      termS3_r;
  logic [prb_pkg::TERM_W-1:0]      termSync_r;

  // Per-bank control.
  logic [prb_pkg::NUM_BANKS-1:0]   bankLoadNow;
  logic [prb_pkg::NUM_BANKS-1:0]   bankInputMode;
  logic [prb_pkg::NUM_BANKS-1:0]   bankCfgErr;
  logic [prb_pkg::NUM_BANKS-1:0]   bankMask;

  // Flop state from the cells.
  logic [prb_pkg::NUM_FF-1:0]      cellQ;
  logic [prb_pkg::NUM_FF-1:0]      oeNxt;

  // Read path.
  logic [prb_pkg::DATA_W-1:0]      regRdata_nxt;

  // Pin synchroniser. A change is accepted only once stages two and three
  // agree, which rejects a single-cycle glitch at the cost of latency.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinS1_r   <= '0;
      pinS2_r   <= '0;
      pinS3_r   <= '0;
      pinSync_r <= '0;
    end else begin
      pinS1_r   <= pinIn;
      pinS2_r   <= pinS1_r;
      pinS3_r   <= pinS2_r;
      pinSync_r <= (pinS2_r & pinS3_r) | (pinSync_r & (pinS2_r | pinS3_r));
    end
  end

  // Product-term input synchroniser, same scheme as the pins.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      termS1_r   <= '0;
      termS2_r   <= '0;
      termS3_r   <= '0;
      termSync_r <= '0;
    end else begin
      termS1_r   <= termIn;
      termS2_r   <= termS1_r;
      termS3_r   <= termS2_r;
      termSync_r <= (termS2_r & termS3_r) | (termSync_r & (termS2_r | termS3_r));
    end
  end

  // Load setting register: one two-bit field per bank.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bankLoadSetting_r <= prb_pkg::RST_LOAD_SET;
    end else if (regWr && regAddr == prb_pkg::OFS_LOAD_SET) begin
      bankLoadSetting_r <= regWdata[prb_pkg::LOAD_SET_W-1:0];
    end
  end

  // Product-term literal selection, one field per bank.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      termMask_r <= prb_pkg::RST_TERM_MASK;
    end else if (regWr && regAddr == prb_pkg::OFS_TERM_MASK) begin
      termMask_r <= regWdata[prb_pkg::TERM_MASK_W-1:0];
    end
  end

  // Flip-flop style per bank: one selects D, zero selects J-K.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dType_r <= prb_pkg::RST_FF_TYPE;
    end else if (regWr && regAddr == prb_pkg::OFS_FF_TYPE) begin
      dType_r <= regWdata[prb_pkg::NUM_BANKS-1:0];
    end
  end

  // Output enable terms per pin.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinOutputEnableTerm_r <= prb_pkg::RST_OE_TERM;
    end else if (regWr && regAddr == prb_pkg::OFS_OE_TERM) begin
      pinOutputEnableTerm_r <= regWdata[prb_pkg::NUM_FF-1:0];
    end
  end

  // Registered input function; chosen per bank, never per flip-flop.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      registeredPinInputFn_r <= prb_pkg::RST_INPUT_FN;
    end else if (regWr && regAddr == prb_pkg::OFS_INPUT_FN) begin
      registeredPinInputFn_r <= regWdata[prb_pkg::NUM_BANKS-1:0];
    end
  end

  // Variant select: enables the M-pin banks and the array masking.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      variantM_r <= prb_pkg::RST_VARIANT;
    end else if (regWr && regAddr == prb_pkg::OFS_VARIANT) begin
      variantM_r <= regWdata[0];
    end
  end

  // Per-bank load decision. It is combinational from registered values so
  // that the source chosen is the one in force at the same clock edge.
  for (genvar b = 0; b < prb_pkg::NUM_BANKS; b++) begin : gBank
    logic [prb_pkg::SET_W-1:0]  setting;
    logic [prb_pkg::TERM_W-1:0] mask;
    logic                       present;
    logic                       termHit;
    logic                       loadNow;

    assign setting = bankLoadSetting_r[b*prb_pkg::SET_W +: prb_pkg::SET_W];
    assign mask    = termMask_r[b*prb_pkg::TERM_W +: prb_pkg::TERM_W];
    // The M-pin banks exist only in the variant.
    assign present = (b < prb_pkg::BANK_M_LOW) || variantM_r;
    // An empty literal set is treated as a false term, not a true one.
    assign termHit = (|mask) && (&(termSync_r | ~mask));

    // A local variable keeps each bank's decision in a process of its own,
    // so no two processes ever write the same vector.
    always_comb begin
      loadNow = 1'b0;
      if (present) begin
        case (setting)
          prb_pkg::LOAD_ONE:  loadNow = 1'b1;
          prb_pkg::LOAD_TERM: loadNow = termHit;
          prb_pkg::LOAD_ZERO: loadNow = 1'b0;
          default:            loadNow = 1'b0;
        endcase
      end
    end
    assign bankLoadNow[b] = loadNow;

    // A bank used as inputs must be under a one or product-term control.
    assign bankInputMode[b] = present && registeredPinInputFn_r[b];
    assign bankCfgErr[b]    = bankInputMode[b] &&
                              !(setting == prb_pkg::LOAD_ONE ||
                                setting == prb_pkg::LOAD_TERM);
    assign bankMask[b]      = variantM_r;
  end

  // One cell per flip-flop; every flop follows its bank's control.
  for (genvar i = 0; i < prb_pkg::NUM_FF; i++) begin : gFlop
    localparam int BANK = i / prb_pkg::BANK_W;

    prb_ff_cell uCell (
      .sys_clk   (sys_clk),
      .arst_n    (arst_n),
      .arrayJ    (arrayJ[i]),
      .arrayK    (arrayK[i]),
      .pinBit    (pinSync_r[i]),
      .loadNow   (bankLoadNow[BANK]),
      .dType     (dType_r[BANK]),
      .maskArray (bankMask[BANK]),
      .q         (cellQ[i])
    );

    // Drivers are held off whenever the bank can take data from its pins,
    // so the external source never fights the pin driver.
    assign oeNxt[i] = pinOutputEnableTerm_r[i] &
                      ~bankInputMode[BANK] &
                      ~(bankLoadSetting_r[BANK*prb_pkg::SET_W +: prb_pkg::SET_W]
                        == prb_pkg::LOAD_ONE) &
                      ~bankLoadNow[BANK];
  end

  // Array feedback comes straight from the cells' flip-flops.
  assign flopQ = cellQ;

  // Pin drive copies the flop state; enable follows the bank's direction.
  // This adds one cycle of latency from flop to pin, the price of keeping
  // every pin output on a flip-flop.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinOut <= '0;
      pinOe  <= '0;
    end else begin
      pinOut <= cellQ;
      pinOe  <= oeNxt;
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    regRdata_nxt = prb_pkg::RD_IDLE;
    case (regAddr)
      prb_pkg::OFS_LOAD_SET:
        regRdata_nxt[prb_pkg::LOAD_SET_W-1:0] = bankLoadSetting_r;
      prb_pkg::OFS_TERM_MASK:
        regRdata_nxt[prb_pkg::TERM_MASK_W-1:0] = termMask_r;
      prb_pkg::OFS_FF_TYPE:
        regRdata_nxt[prb_pkg::NUM_BANKS-1:0] = dType_r;
      prb_pkg::OFS_OE_TERM:
        regRdata_nxt[prb_pkg::NUM_FF-1:0] = pinOutputEnableTerm_r;
      prb_pkg::OFS_INPUT_FN:
        regRdata_nxt[prb_pkg::NUM_BANKS-1:0] = registeredPinInputFn_r;
      prb_pkg::OFS_VARIANT:
        regRdata_nxt[0] = variantM_r;
      prb_pkg::OFS_FF_STATE:
        regRdata_nxt[prb_pkg::NUM_FF-1:0] = cellQ;
      prb_pkg::OFS_PIN_STATE:
        regRdata_nxt[prb_pkg::NUM_FF-1:0] = pinSync_r;
      prb_pkg::OFS_STATUS: begin
        regRdata_nxt[prb_pkg::NUM_BANKS-1:0] = bankLoadNow;
        regRdata_nxt[2*prb_pkg::NUM_BANKS-1:prb_pkg::NUM_BANKS] = bankCfgErr;
      end
      default:
        regRdata_nxt = prb_pkg::RD_IDLE;
    endcase
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= prb_pkg::RD_IDLE;
    end else if (regRd) begin
      regRdata <= regRdata_nxt;
    end else begin
      regRdata <= prb_pkg::RD_IDLE;
    end
  end

endmodule // prb_register_bank

// ---- verif/prb_register_bank_sva.sv ----
// Port checker for the bank register block, bound to its top module.
// Assumes it sees every write, so it shadows the few configuration fields it needs.
`timescale 1ns/1ps

module prb_register_bank_sva (
  // Clock and reset
  input wire logic                       sys_clk,
  input wire logic                       arst_n,
  // Register port
  input wire logic [prb_pkg::ADDR_W-1:0] regAddr,
  input wire logic [prb_pkg::DATA_W-1:0] regWdata,
  input wire logic                       regWr,
  input wire logic                       regRd,
  input wire logic [prb_pkg::DATA_W-1:0] regRdata,
  // Array, flops and pins
  input wire logic [prb_pkg::NUM_FF-1:0] arrayJ,
  input wire logic [prb_pkg::NUM_FF-1:0] arrayK,
  input wire logic [prb_pkg::NUM_FF-1:0] flopQ,
  input wire logic [prb_pkg::NUM_FF-1:0] pinIn,
  input wire logic [prb_pkg::NUM_FF-1:0] pinOut,
  input wire logic [prb_pkg::NUM_FF-1:0] pinOe
);
  logic [7:0] cfgSet_r;
  logic [3:0] cfgType_r;
  logic       cfgVar_r;
  logic       b0One;

  // The shadows update on the same edge as the real fields, so they match cycle for cycle.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfgSet_r <= 8'h00;
      cfgType_r <= 4'h0;
      cfgVar_r <= 1'b0;
    end else if (regWr) begin
      if (regAddr == prb_pkg::OFS_LOAD_SET) cfgSet_r <= regWdata[7:0];
      if (regAddr == prb_pkg::OFS_FF_TYPE) cfgType_r <= regWdata[3:0];
      if (regAddr == prb_pkg::OFS_VARIANT) cfgVar_r <= regWdata[0];
    end
  end

  assign b0One = (cfgSet_r[1:0] == prb_pkg::LOAD_ONE);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  property p_rd_idle;
    !regRd |=> regRdata == prb_pkg::RD_IDLE;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_pin_copy;
    1'b1 |=> pinOut == $past(flopQ);
  endproperty
  a_pin_copy: assert property (p_pin_copy) else $error("pin copy wrong");
  property p_oe_off;
    b0One |=> pinOe[3:0] == 4'h0;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("input bank drives");
  property p_pin_load;
    (b0One && arrayJ[3:0] == 4'h0 && arrayK[3:0] == 4'h0 && $stable(pinIn[3:0]))[*7]
      |-> flopQ[3:0] == pinIn[3:0];
  endproperty
  a_pin_load: assert property (p_pin_load) else $error("pin load missed");
  property p_mask;
    (cfgVar_r && b0One && $stable(pinIn[3:0]))[*7] |-> flopQ[3:0] == pinIn[3:0];
  endproperty
  a_mask: assert property (p_mask) else $error("array not masked");
  property p_array_only;
    (!cfgType_r[0] && !b0One && cfgSet_r[1:0] != prb_pkg::LOAD_TERM
      && arrayJ[3:0] == 4'h0 && arrayK[3:0] == 4'h0) |=> $stable(flopQ[3:0]);
  endproperty
  a_array_only: assert property (p_array_only) else $error("bank took pins");
  property p_toggle;
    (!cfgType_r[0] && cfgSet_r[1:0] == prb_pkg::LOAD_NONE && arrayJ[0] && arrayK[0])
      |=> flopQ[0] != $past(flopQ[0]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle");
  property p_dominate;
    (!cfgType_r[0] && b0One && !cfgVar_r && arrayJ[0] && arrayK[0])
      |=> flopQ[0] != $past(flopQ[0]);
  endproperty
  a_dominate: assert property (p_dominate) else $error("high term lost");
  property p_dmode;
    (cfgType_r[0] && cfgSet_r[1:0] == prb_pkg::LOAD_ZERO) |=> flopQ[0] == $past(arrayJ[0]);
  endproperty
  a_dmode: assert property (p_dmode) else $error("D flop wrong");
  property p_no_mbank;
    (!cfgVar_r && !cfgType_r[2] && arrayJ[11:8] == 4'h0 && arrayK[11:8] == 4'h0)
      |=> $stable(flopQ[11:8]);
  endproperty
  a_no_mbank: assert property (p_no_mbank) else $error("absent bank loaded");

  c_pin_load: cover property (b0One ##8 b0One);
  c_mask: cover property (cfgVar_r && b0One);
  c_toggle: cover property (arrayJ[0] && arrayK[0] && !cfgType_r[0]);
endmodule // prb_register_bank_sva

bind prb_register_bank prb_register_bank_sva chk (.sys_clk(sys_clk), .arst_n(arst_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .arrayJ(arrayJ), .arrayK(arrayK), .flopQ(flopQ),
  .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));

// ---- verif/prb_pin_source.sv ----
// External source on the sixteen pins, resolving the wire against the device.
// Assumes the bench releases bits that the device is expected to drive.
`timescale 1ns/1ps

module prb_pin_source (
  // Clock
  input wire logic        sys_clk,
  // Device side
  input wire logic [15:0] pinOut,
  input wire logic [15:0] pinOe,
  // Source control
  input wire logic [15:0] srcVal,
  input wire logic [15:0] srcEn,
  // Wire level
  output logic     [15:0] pinIn
);
  // An unpulled, undriven pin wanders, so it must never look like a held level.
  logic [15:0] float_r = 16'h5A5A;

  always_ff @(posedge sys_clk) begin
    float_r <= ~float_r;
  end

  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pinOe[i] && srcEn[i]) pinIn[i] = 1'bx;
      else if (pinOe[i]) pinIn[i] = pinOut[i];
      else if (srcEn[i]) pinIn[i] = srcVal[i];
      else pinIn[i] = float_r[i];
    end
  end
endmodule // prb_pin_source

// ---- verif/prb_register_bank_test.sv ----
// Self-checking bench for the bank register block with a pin source model.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps

module prb_register_bank_test;
  logic        sys_clk;
  logic        arst_n;
  logic [5:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdata;
  logic [15:0] arrayJ, arrayK, flopQ, pinIn, pinOut, pinOe, srcVal, srcEn;
  logic [3:0]  termIn;
  logic [31:0] rdv;
  int          miscompares;
  int          n_tests;
  int          cycles;

  typedef struct packed {
    logic [1:0] set;
    logic       dt;
    logic [3:0] term, pin, aj, exp;
  } prb_row_t;
  prb_row_t rows [5] = '{
    '{prb_pkg::LOAD_ZERO, 1'b1, 4'h0, 4'hF, 4'h5, 4'h5},
    '{prb_pkg::LOAD_NONE, 1'b1, 4'h0, 4'hF, 4'hA, 4'hA},
    '{prb_pkg::LOAD_ONE, 1'b1, 4'h0, 4'h6, 4'h0, 4'h6},
    '{prb_pkg::LOAD_TERM, 1'b1, 4'h3, 4'h9, 4'h0, 4'h9},
    '{prb_pkg::LOAD_TERM, 1'b1, 4'h1, 4'h3, 4'hC, 4'hC}};

  prb_register_bank dut (.sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .arrayJ(arrayJ), .arrayK(arrayK), .flopQ(flopQ), .termIn(termIn),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
  prb_pin_source src (.sys_clk(sys_clk), .pinOut(pinOut), .pinOe(pinOe),
    .srcVal(srcVal), .srcEn(srcEn), .pinIn(pinIn));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // A hang is cut short well past the roughly 170 cycles the run needs.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    arst_n = 1'b0;
    {regAddr, regWdata, regWr, regRd, arrayJ, arrayK, termIn, srcVal} = '0;
    srcEn = 16'hFFFF;
    cyc(2);
    arst_n <= 1'b1;
    #1 chk("reset outputs", 32'h0, {flopQ, pinOe});
    for (int a = 0; a < 64; a += 4) begin
      rd(6'(a), rdv);
      chk("reset read", 32'h0, rdv);
    end
    wr(prb_pkg::OFS_TERM_MASK, 32'h3);
    foreach (rows[i]) begin
      wr(prb_pkg::OFS_LOAD_SET, {30'h0, rows[i].set});
      wr(prb_pkg::OFS_FF_TYPE, {31'h0, rows[i].dt});
      termIn <= rows[i].term;
      srcVal <= {12'h000, rows[i].pin};
      arrayJ <= {12'h000, rows[i].aj};
      cyc(8);
      #1 chk("row q", {28'h0, rows[i].exp}, {16'h0, flopQ});
      chk("row pin", {28'h0, rows[i].exp}, {16'h0, pinOut});
      rd(prb_pkg::OFS_FF_STATE, rdv);
      chk("row read", {28'h0, rows[i].exp}, rdv);
    end
    wr(prb_pkg::OFS_LOAD_SET, 32'h0);
    wr(prb_pkg::OFS_FF_TYPE, 32'h0);
    arrayJ <= 16'h000F;
    arrayK <= 16'h000F;
    cyc(1);
    arrayJ <= 16'h0;
    arrayK <= 16'h0;
    cyc(1);
    #1 chk("toggle", 32'h3, {28'h0, flopQ[3:0]});
    wr(prb_pkg::OFS_LOAD_SET, {30'h0, prb_pkg::LOAD_ONE});
    cyc(2);
    arrayJ <= 16'h0001;
    arrayK <= 16'h0001;
    cyc(1);
    arrayJ <= 16'h0;
    arrayK <= 16'h0;
    #1 chk("dominate", 32'h2, {28'h0, flopQ[3:0]});
    wr(prb_pkg::OFS_VARIANT, 32'h1);
    arrayJ <= 16'h000F;
    arrayK <= 16'h000F;
    srcVal <= 16'h0005;
    cyc(8);
    #1 chk("masked", 32'h5, {28'h0, flopQ[3:0]});
    @(posedge sys_clk);
    arrayJ <= 16'h0;
    arrayK <= 16'h0;
    wr(prb_pkg::OFS_LOAD_SET, 32'h22);
    srcVal <= 16'h0A05;
    cyc(8);
    #1 chk("m bank on", 32'hA, {28'h0, flopQ[11:8]});
    wr(prb_pkg::OFS_VARIANT, 32'h0);
    srcVal <= 16'h0505;
    cyc(8);
    #1 chk("m bank off", 32'hA, {28'h0, flopQ[11:8]});
    srcVal <= 16'h0A05;
    srcEn <= 16'h0FFF;
    // Input function first, so the input bank never drives against the source.
    wr(prb_pkg::OFS_INPUT_FN, 32'h2);
    wr(prb_pkg::OFS_OE_TERM, 32'hFFFF);
    cyc(3);
    #1 chk("oe", 32'hF000, {16'h0, pinOe});
    rd(prb_pkg::OFS_STATUS, rdv);
    chk("status", 32'h21, rdv);
    wr(prb_pkg::OFS_FF_STATE, 32'hFFFFFFFF);
    rd(prb_pkg::OFS_FF_STATE, rdv);
    chk("read only", 32'h0A05, rdv);
    rd(prb_pkg::OFS_PIN_STATE, rdv);
    chk("pin state", 32'h0A05, rdv);
    cyc(1);
    arst_n <= 1'b0;
    cyc(2);
    #1 chk("mid reset", 32'h0, {flopQ, pinOe});
    cyc(1);
    arst_n <= 1'b1;
    rd(prb_pkg::OFS_LOAD_SET, rdv);
    chk("reset setting", 32'h0, rdv);
    summarize();
  end
endmodule // prb_register_bank_test
